// File: rtl/fpet_regs.vh
`ifndef FPET_REGS_VH
`define FPET_REGS_VH
// Phase lengths in flash timing clock periods
`define FPET_T_WORD 16'h001E
`define FPET_T_BLK_FIRST 16'h0019
`define FPET_T_BLK_NEXT 16'h0012
`define FPET_T_BLK_END 16'h0006
`define FPET_T_MASS 16'h2961
`define FPET_T_SEG 16'h12D3
`define FPET_BLK_LAST 6'h3F
// Operation codes
`define FPET_OP_WORD 2'h0
`define FPET_OP_BLOCK 2'h1
`define FPET_OP_SEG 2'h2
`define FPET_OP_MASS 2'h3
`define FPET_CNT_W 16
`endif

// File: rtl/fpet_tick.v
`timescale 1ns/1ps
// Three-stage synchroniser and edge detector for the flash timing clock
module fpet_tick (
  input wire clk, // System clock
  input wire rst, // Synchronous reset
  input wire ce, // Clock enable
  input wire ftg_in, // Asynchronous flash timing clock
  output reg tick // One pulse per timing clock period
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  reg lvl_r;
  always @(posedge clk) begin
    if (rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      lvl_r <= 1'b0;
      tick <= 1'b0;
    end else if (ce) begin
      s1_r <= ftg_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      tick <= 1'b0;
      // A change is accepted only once stages two and three agree
      if (s2_r == s3_r && s3_r != lvl_r) begin
        lvl_r <= s3_r;
        tick <= s3_r;
      end
    end
  end
endmodule // fpet_tick

// File: rtl/fpet_timer.v
// Summary of operation
// - Word or byte program lasts 30 periods
// - Block first word lasts 25 periods
// - Block words one to 63: 18 each
// - Block end sequence waits 6 periods
// - Mass erase 10593, segment erase 4819 periods
`timescale 1ns/1ps
`include "fpet_regs.vh"
module fpet_timer (
  input wire CLOCK, // 200 MHz system clock
  input wire RST, // Synchronous reset, active high
  input wire CE, // Clock enable, freezes all state when low
  input wire FTG_CLK, // Flash timing clock from its generator
  input wire START, // Start pulse for an operation
  input wire [1:0] OP, // Operation code taken with START
  input wire DATA_VALID, // Next block word is ready
  input wire BLOCK_STOP, // Software ends a block write early
  output wire BUSY, // Sequence in progress
  output wire REJECT, // Start refused while busy
  output reg PROG_EN, // Array program phase active
  output reg ERASE_EN, // Array erase phase active
  output reg WORD_DONE, // Pulse at end of each programmed word
  output reg [5:0] BLK_INDEX, // Position within the block
  output reg DONE // Pulse when the sequence ends
);
  localparam ST_IDLE = 6'b000001;
  localparam ST_WORD = 6'b000010;
  localparam ST_BFIRST = 6'b000100;
  localparam ST_BWAIT = 6'b001000;
  localparam ST_BNEXT = 6'b010000;
  localparam ST_ERASE = 6'b100000;
  reg [5:0] state_r;
  reg end_r;
  reg [`FPET_CNT_W-1:0] cnt_r;
  reg mass_r;
  wire tick;
  wire cnt_last;
  fpet_tick u_tick (
    .clk(CLOCK),
    .rst(RST),
    .ce(CE),
    .ftg_in(FTG_CLK),
    .tick(tick)
  );
  assign cnt_last = tick && (cnt_r == 16'h0001);
  assign BUSY = (state_r != ST_IDLE) || end_r;
  assign REJECT = START && BUSY;
  always @(posedge CLOCK) begin
    if (RST) begin
      state_r <= ST_IDLE;
      end_r <= 1'b0;
      cnt_r <= 16'h0000;
      mass_r <= 1'b0;
      PROG_EN <= 1'b0;
      ERASE_EN <= 1'b0;
      WORD_DONE <= 1'b0;
      BLK_INDEX <= 6'h00;
      DONE <= 1'b0;
    end else if (CE) begin
      WORD_DONE <= 1'b0;
      DONE <= 1'b0;
      if (tick && cnt_r != 16'h0000)
        cnt_r <= cnt_r - 16'h0001;
      if (end_r) begin
        if (cnt_last) begin
          end_r <= 1'b0;
          state_r <= ST_IDLE;
          DONE <= 1'b1;
        end
      end else begin
        case (state_r)
          ST_IDLE: begin
            if (START) begin
              BLK_INDEX <= 6'h00;
              case (OP)
                `FPET_OP_WORD: begin
                  state_r <= ST_WORD;
                  cnt_r <= `FPET_T_WORD;
                  PROG_EN <= 1'b1;
                end
                `FPET_OP_BLOCK: begin
                  state_r <= ST_BFIRST;
                  cnt_r <= `FPET_T_BLK_FIRST;
                  PROG_EN <= 1'b1;
                end
                `FPET_OP_MASS: begin
                  state_r <= ST_ERASE;
                  mass_r <= 1'b1;
                  cnt_r <= `FPET_T_MASS;
                  ERASE_EN <= 1'b1;
                end
                default: begin
                  state_r <= ST_ERASE;
                  mass_r <= 1'b0;
                  cnt_r <= `FPET_T_SEG;
                  ERASE_EN <= 1'b1;
                end
              endcase
            end
          end
          ST_WORD: begin
            if (cnt_last) begin
              PROG_EN <= 1'b0;
              WORD_DONE <= 1'b1;
              DONE <= 1'b1;
              state_r <= ST_IDLE;
            end
          end
          ST_BFIRST, ST_BNEXT: begin
            if (cnt_last) begin
              PROG_EN <= 1'b0;
              WORD_DONE <= 1'b1;
              if (BLK_INDEX == `FPET_BLK_LAST) begin
                end_r <= 1'b1;
                cnt_r <= `FPET_T_BLK_END;
              end else begin
                state_r <= ST_BWAIT;
              end
            end
          end
          ST_BWAIT: begin
            // Programming voltage stays off between words while data is awaited
            if (BLOCK_STOP) begin
              end_r <= 1'b1;
              cnt_r <= `FPET_T_BLK_END;
            end else if (DATA_VALID) begin
              state_r <= ST_BNEXT;
              BLK_INDEX <= BLK_INDEX + 6'h01;
              cnt_r <= `FPET_T_BLK_NEXT;
              PROG_EN <= 1'b1;
            end
          end
          ST_ERASE: begin
            if (cnt_last) begin
              ERASE_EN <= 1'b0;
              mass_r <= 1'b0;
              DONE <= 1'b1;
              state_r <= ST_IDLE;
            end
          end
          default: begin
            state_r <= ST_IDLE;
            PROG_EN <= 1'b0;
            ERASE_EN <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule // fpet_timer

// File: dv/fpet_monitor.sv
`timescale 1ns/1ps
module fpet_monitor (
  input wire CLOCK, // Clock
  input wire RST, // Reset
  input wire CE, // Enable
  input wire START, // Request
  input wire [1:0] OP, // Operation
  input wire BUSY, // Busy
  input wire REJECT, // Refused
  input wire PROG_EN, // Program
  input wire ERASE_EN, // Erase
  input wire DONE // End
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  sequence s_take;
    CE && START && !BUSY;
  endsequence
  a_word_hold: assert property (s_take ##0 OP == 2'h0 |=> (BUSY && !DONE)[*8])
    else $error("Word ended early");
  a_block_prog: assert property (s_take ##0 OP == 2'h1 |=> PROG_EN)
    else $error("Block not programming");
  a_erase_only: assert property (s_take ##0 OP[1] |=> ERASE_EN && !PROG_EN)
    else $error("Erase phase wrong");
  a_reject_busy: assert property (START && BUSY |-> REJECT)
    else $error("Busy start not refused");
  a_done_release: assert property (DONE |=> !BUSY && !DONE)
    else $error("Busy after end");
  a_end_quiet: assert property (DONE |-> !PROG_EN && !ERASE_EN)
    else $error("Array active at end");
endmodule // fpet_monitor

// File: dv/fpet_array.sv
`timescale 1ns/1ps
// Rate scaled far above the legal band so long erases fit a short run
module fpet_array (
  input wire clk, // System clock
  input wire word_done, // Word written
  output reg ftg_clk = 1'b0, // Timing clock
  output reg [6:0] words = 7'h00 // Words written
);
  reg half_r = 1'b0;
  always @(posedge clk) begin
    half_r <= ~half_r;
    if (half_r) ftg_clk <= ~ftg_clk;
    if (word_done) words <= words + 7'h01;
  end
endmodule // fpet_array

// File: dv/tb_top.sv
`timescale 1ns/1ps
`include "fpet_regs.vh"
module tb_top;
  reg CLOCK = 1'b0;
  reg RST = 1'b1;
  reg START = 1'b0;
  reg [1:0] OP = 2'h0;
  reg DATA_VALID = 1'b1;
  reg BLOCK_STOP = 1'b0;
  wire BUSY, REJECT, PROG_EN, ERASE_EN, WORD_DONE, DONE, FTG_CLK;
  wire [5:0] BLK_INDEX;
  wire [6:0] words;
  integer errors = 0;
  integer samples_checked = 0;
  integer cyc = 0;
  fpet_timer u_dut (.CLOCK(CLOCK), .RST(RST), .CE(1'b1), .FTG_CLK(FTG_CLK), .START(START), .OP(OP),
    .DATA_VALID(DATA_VALID), .BLOCK_STOP(BLOCK_STOP), .BUSY(BUSY), .REJECT(REJECT), .PROG_EN(PROG_EN),
    .ERASE_EN(ERASE_EN), .WORD_DONE(WORD_DONE), .BLK_INDEX(BLK_INDEX), .DONE(DONE));
  fpet_array u_array (.clk(CLOCK), .word_done(WORD_DONE), .ftg_clk(FTG_CLK), .words(words));
  initial forever #2.5 CLOCK = ~CLOCK;
  task end_of_test;
    begin
      $display("Mismatches %0d of %0d checks", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  always @(posedge CLOCK) begin
    cyc = cyc + 1;
    if (cyc == 80000) begin
      errors = errors + 1;
      end_of_test;
    end
  end
  task check(input [31:0] seen, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // Start just after a timing edge: with a 4-cycle timing period the end lands 4n cycles later
  task run_op(input [1:0] op, input [15:0] n, input rej);
    integer d;
    begin
      @(posedge FTG_CLK);
      #1 START = 1'b1;
      OP = op;
      @(posedge CLOCK);
      #1 START = rej;
      d = 0;
      if (rej) check(REJECT, 1);
      while (DONE !== 1'b1) begin
        @(posedge CLOCK);
        #1 START = 1'b0;
        d = d + 1;
      end
      check(d >= 4 * n - 1 && d <= 4 * n + 1, 1);
      @(posedge CLOCK);
      #1 check(BUSY, 0);
    end
  endtask
  task t_word;
    begin
      run_op(`FPET_OP_WORD, `FPET_T_WORD, 1'b1);
      check(words, 7'h01);
    end
  endtask
  task t_block;
    begin
      run_op(`FPET_OP_BLOCK, `FPET_T_BLK_FIRST + `FPET_BLK_LAST * `FPET_T_BLK_NEXT + `FPET_T_BLK_END, 1'b0);
      check(words, 7'h41);
      check(BLK_INDEX, `FPET_BLK_LAST);
    end
  endtask
  // Block cut after its first word: end wait follows the first word directly
  task t_stop;
    begin
      DATA_VALID = 1'b0;
      BLOCK_STOP = 1'b1;
      run_op(`FPET_OP_BLOCK, `FPET_T_BLK_FIRST + `FPET_T_BLK_END, 1'b0);
      check(words, 7'h42);
      check(BLK_INDEX, 6'h00);
      DATA_VALID = 1'b1;
      BLOCK_STOP = 1'b0;
    end
  endtask
  task t_erase;
    begin
      run_op(`FPET_OP_SEG, `FPET_T_SEG, 1'b0);
      run_op(`FPET_OP_MASS, `FPET_T_MASS, 1'b0);
    end
  endtask
  initial begin
    repeat (3) @(posedge CLOCK);
    #1 RST = 1'b0;
    t_word;
    t_block;
    t_stop;
    t_erase;
    end_of_test;
  end
endmodule // tb_top
bind fpet_timer fpet_monitor u_mon (.CLOCK(CLOCK), .RST(RST), .CE(CE), .START(START), .OP(OP), .BUSY(BUSY),
  .REJECT(REJECT), .PROG_EN(PROG_EN), .ERASE_EN(ERASE_EN), .DONE(DONE));
